//--- design/ppc_pkg.sv
// ppc_pkg: register map, reset values and field constants for the port pin configuration block
package ppc_pkg;

	// ------------------------------------------------------------
	// widths
	// ------------------------------------------------------------
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 8;
	localparam int unsigned PAGE_W = 8;
	localparam int unsigned BIT_W  = 3;

	// ------------------------------------------------------------
	// register addresses and pages
	// ------------------------------------------------------------
	localparam logic [ADDR_W-1:0] ADDR_P2_DATA    = 8'h00_A0;
	localparam logic [ADDR_W-1:0] ADDR_P1_OUTDRV  = 8'h00_A5;
	localparam logic [ADDR_W-1:0] ADDR_P2_BYPASS  = 8'h00_D6;
	localparam logic [ADDR_W-1:0] ADDR_P1_ANALOG  = 8'h00_F2;
	localparam logic [ADDR_W-1:0] ADDR_P2_ANALOG  = 8'h00_F3;
	localparam logic [PAGE_W-1:0] PAGE_BASE       = 8'h00_00;
	localparam logic [PAGE_W-1:0] PAGE_CONFIG     = 8'h00_0F;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [DATA_W-1:0] RST_ONES  = 8'h00_FF;
	localparam logic [DATA_W-1:0] RST_ZEROS = 8'h00_00;

	// ------------------------------------------------------------
	// fields
	// ------------------------------------------------------------
	localparam int unsigned       P2_RSVD_BIT = 7;
	localparam logic [DATA_W-1:0] P2_RSVD_MSK = 8'h00_80;
	localparam logic [DATA_W-1:0] P1_RADIO_MSK = 8'h00_17;
	localparam logic [DATA_W-1:0] P1_NC_MSK    = 8'h00_08;

	// ------------------------------------------------------------
	// register selector
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		SEL_NONE,
		SEL_P2_DATA,
		SEL_P1_OTYPE,
		SEL_P1_DRIVE,
		SEL_P2_BYPASS,
		SEL_P1_ANALOG,
		SEL_P2_ANALOG
	} ppc_sel_t;

	// analog select of 0 means analog mode
	function automatic logic [DATA_W-1:0] ppc_digital_en(input logic [DATA_W-1:0] analog_sel);
		return analog_sel;
	endfunction : ppc_digital_en

endpackage : ppc_pkg

//--- design/ppc_cfg_if.sv
// ppc_cfg_if: decoded register access carried between the top and its helpers
`timescale 1ns/1ps
interface ppc_cfg_if;
	import ppc_pkg::*;
	ppc_sel_t              sel;
	logic                  wr;
	logic                  bit_wr;
	logic [BIT_W-1:0]      bit_idx;
	logic                  bit_val;
	logic [DATA_W-1:0]     wdata;
	modport dec_mp (output sel);
	modport use_mp (input sel, input wr, input bit_wr, input bit_idx, input bit_val, input wdata);
	modport drv_mp (output wr, output bit_wr, output bit_idx, output bit_val, output wdata);
endinterface : ppc_cfg_if

//--- design/ppc_decode.sv
// ppc_decode: maps page and address to one register of the block
`timescale 1ns/1ps
module ppc_decode
	import ppc_pkg::*;
(
	// register bus address
	input  wire logic [ADDR_W-1:0] addr_i,
	input  wire logic [PAGE_W-1:0] page_i,
	// decoded selector
	ppc_cfg_if.dec_mp              cfg
);

	always_comb begin
		cfg.sel = SEL_NONE;
		case (addr_i)
			ADDR_P2_DATA: cfg.sel = SEL_P2_DATA;
			ADDR_P1_OUTDRV: begin
				if (page_i == PAGE_CONFIG) begin
					cfg.sel = SEL_P1_DRIVE;
				end else if (page_i == PAGE_BASE) begin
					cfg.sel = SEL_P1_OTYPE;
				end
			end
			ADDR_P2_BYPASS: cfg.sel = (page_i == PAGE_BASE) ? SEL_P2_BYPASS : SEL_NONE;
			ADDR_P1_ANALOG: cfg.sel = (page_i == PAGE_BASE) ? SEL_P1_ANALOG : SEL_NONE;
			ADDR_P2_ANALOG: cfg.sel = (page_i == PAGE_BASE) ? SEL_P2_ANALOG : SEL_NONE;
			default: cfg.sel = SEL_NONE;
		endcase
	end

endmodule : ppc_decode

//--- design/ppc_reg8.sv
// ppc_reg8: one 8-bit configuration register with byte and single-bit write
`timescale 1ns/1ps
module ppc_reg8
	import ppc_pkg::*;
#(
	parameter ppc_sel_t          MY_SEL  = SEL_NONE,
	parameter logic [DATA_W-1:0] RST_VAL = RST_ZEROS,
	parameter logic [DATA_W-1:0] FIX_MSK = RST_ZEROS
)
(
	// clock and reset
	input  wire logic              sys_clk_i,
	input  wire logic              resetn_i,
	// access
	ppc_cfg_if.use_mp              cfg,
	// value
	output      logic [DATA_W-1:0] q_o
);

	typedef struct packed {
		logic [DATA_W-1:0] val;
	} ppc_reg_state_t;

	ppc_reg_state_t st_q;
	ppc_reg_state_t st_d;

	always_comb begin
		st_d = st_q;
		if (cfg.sel == MY_SEL && cfg.wr) begin
			st_d.val = cfg.wdata;
		end else if (cfg.sel == MY_SEL && cfg.bit_wr) begin
			st_d.val[cfg.bit_idx] = cfg.bit_val;
		end
		st_d.val = st_d.val | FIX_MSK;
	end

	always_ff @(posedge sys_clk_i) begin
		if (!resetn_i) begin
			st_q.val <= RST_VAL;
		end else begin
			st_q <= st_d;
		end
	end

	assign q_o = st_q.val;

endmodule : ppc_reg8

//--- design/ppc_port_cfg.sv
// ppc_port_cfg: configuration and data registers with pin control for ports 1 and 2
`timescale 1ns/1ps
module ppc_port_cfg
	import ppc_pkg::*;
#(
	parameter int unsigned PORT_W = DATA_W
)
(
	// clock and reset
	input  wire logic              sys_clk_i,
	input  wire logic              resetn_i,
	// special function register bus
	input  wire logic [ADDR_W-1:0] sfr_addr_i,
	input  wire logic [PAGE_W-1:0] sfr_page_i,
	input  wire logic              sfr_wr_i,
	input  wire logic              sfr_rd_i,
	input  wire logic              sfr_bit_wr_i,
	input  wire logic [BIT_W-1:0]  sfr_bit_idx_i,
	input  wire logic              sfr_bit_val_i,
	input  wire logic [DATA_W-1:0] sfr_wdata_i,
	output      logic [DATA_W-1:0] sfr_rdata_o,
	output      logic              sfr_hit_o,
	// port 1 pads
	input  wire logic [PORT_W-1:0] p1_pin_i,
	output      logic [PORT_W-1:0] p1_pin_o,
	output      logic [PORT_W-1:0] p1_pin_oe_o,
	output      logic [PORT_W-1:0] p1_pullup_en_o,
	output      logic [PORT_W-1:0] p1_rx_en_o,
	output      logic [PORT_W-1:0] p1_high_drive_o,
	// port 1 radio side
	input  wire logic [PORT_W-1:0] p1_out_i,
	output      logic [PORT_W-1:0] p1_radio_in_o,
	// port 2 pads
	input  wire logic [PORT_W-1:0] p2_pin_i,
	output      logic [PORT_W-1:0] p2_pin_o,
	output      logic [PORT_W-1:0] p2_pin_oe_o,
	output      logic [PORT_W-1:0] p2_pullup_en_o,
	output      logic [PORT_W-1:0] p2_rx_en_o,
	// crossbar
	output      logic [PORT_W-1:0] p2_skip_o
);

	// ------------------------------------------------------------
	// decode and registers
	// ------------------------------------------------------------
	ppc_cfg_if cfg ();

	assign cfg.wr      = sfr_wr_i;
	assign cfg.bit_wr  = sfr_bit_wr_i;
	assign cfg.bit_idx = sfr_bit_idx_i;
	assign cfg.bit_val = sfr_bit_val_i;
	assign cfg.wdata   = sfr_wdata_i;

	ppc_decode u_dec (
		.addr_i (sfr_addr_i),
		.page_i (sfr_page_i),
		.cfg    (cfg)
	);

	logic [DATA_W-1:0] p2_data;
	logic [DATA_W-1:0] p1_otype;
	logic [DATA_W-1:0] p1_drive;
	logic [DATA_W-1:0] p2_bypass;
	logic [DATA_W-1:0] p1_analog;
	logic [DATA_W-1:0] p2_analog;

	ppc_reg8 #(.MY_SEL(SEL_P2_DATA), .RST_VAL(RST_ONES), .FIX_MSK(RST_ZEROS)) u_p2_data (
		.sys_clk_i (sys_clk_i),
		.resetn_i  (resetn_i),
		.cfg       (cfg),
		.q_o       (p2_data)
	);
	ppc_reg8 #(.MY_SEL(SEL_P1_OTYPE), .RST_VAL(RST_ZEROS), .FIX_MSK(RST_ZEROS)) u_p1_otype (
		.sys_clk_i (sys_clk_i),
		.resetn_i  (resetn_i),
		.cfg       (cfg),
		.q_o       (p1_otype)
	);
	ppc_reg8 #(.MY_SEL(SEL_P1_DRIVE), .RST_VAL(RST_ZEROS), .FIX_MSK(RST_ZEROS)) u_p1_drive (
		.sys_clk_i (sys_clk_i),
		.resetn_i  (resetn_i),
		.cfg       (cfg),
		.q_o       (p1_drive)
	);
	ppc_reg8 #(.MY_SEL(SEL_P2_BYPASS), .RST_VAL(RST_ZEROS), .FIX_MSK(RST_ZEROS)) u_p2_bypass (
		.sys_clk_i (sys_clk_i),
		.resetn_i  (resetn_i),
		.cfg       (cfg),
		.q_o       (p2_bypass)
	);
	ppc_reg8 #(.MY_SEL(SEL_P1_ANALOG), .RST_VAL(RST_ONES), .FIX_MSK(RST_ZEROS)) u_p1_analog (
		.sys_clk_i (sys_clk_i),
		.resetn_i  (resetn_i),
		.cfg       (cfg),
		.q_o       (p1_analog)
	);
	ppc_reg8 #(.MY_SEL(SEL_P2_ANALOG), .RST_VAL(RST_ONES), .FIX_MSK(P2_RSVD_MSK)) u_p2_analog (
		.sys_clk_i (sys_clk_i),
		.resetn_i  (resetn_i),
		.cfg       (cfg),
		.q_o       (p2_analog)
	);

	// ------------------------------------------------------------
	// output state
	// ------------------------------------------------------------
	typedef struct packed {
		logic [DATA_W-1:0] rdata;
		logic              hit;
		logic [PORT_W-1:0] p1_o;
		logic [PORT_W-1:0] p1_oe;
		logic [PORT_W-1:0] p1_pu;
		logic [PORT_W-1:0] p1_rx;
		logic [PORT_W-1:0] p1_hd;
		logic [PORT_W-1:0] p1_rin;
		logic [PORT_W-1:0] p2_o;
		logic [PORT_W-1:0] p2_oe;
		logic [PORT_W-1:0] p2_pu;
		logic [PORT_W-1:0] p2_rx;
		logic [PORT_W-1:0] p2_sk;
	} ppc_top_state_t;

	ppc_top_state_t st_q;
	ppc_top_state_t st_d;

	logic [PORT_W-1:0] p1_dig;
	logic [PORT_W-1:0] p2_dig;
	logic [PORT_W-1:0] p1_ext;
	logic [PORT_W-1:0] p2_pin_st;

	always_comb begin
		p1_dig    = ppc_digital_en(p1_analog);
		p2_dig    = ppc_digital_en(p2_analog);
		p1_ext    = ~(P1_RADIO_MSK | P1_NC_MSK);
		p2_pin_st = p2_pin_i & p2_dig;
		st_d      = st_q;

		// register read back
		st_d.hit   = (cfg.sel != SEL_NONE) && sfr_rd_i;
		st_d.rdata = st_q.rdata;
		if (sfr_rd_i) begin
			case (cfg.sel)
				SEL_P2_DATA:   st_d.rdata = p2_pin_st;
				SEL_P1_OTYPE:  st_d.rdata = p1_otype;
				SEL_P1_DRIVE:  st_d.rdata = p1_drive;
				SEL_P2_BYPASS: st_d.rdata = p2_bypass;
				SEL_P1_ANALOG: st_d.rdata = p1_analog;
				SEL_P2_ANALOG: st_d.rdata = p2_analog | P2_RSVD_MSK;
				default:       st_d.rdata = RST_ZEROS;
			endcase
		end

		// port 1: latch driven by the core side, radio pins internal
		st_d.p1_o   = p1_out_i;
		st_d.p1_oe  = (p1_otype | ~p1_out_i) & p1_ext;
		st_d.p1_pu  = p1_dig & p1_ext;
		st_d.p1_rx  = p1_dig & p1_ext;
		st_d.p1_hd  = p1_drive & p1_ext;
		st_d.p1_rin = p1_out_i & P1_RADIO_MSK;

		// port 2: open-drain drives low only, push-pull unknown here so open-drain
		st_d.p2_o   = p2_data;
		st_d.p2_oe  = ~p2_data;
		st_d.p2_pu  = p2_dig;
		st_d.p2_rx  = p2_dig;
		st_d.p2_sk  = p2_bypass;
	end

	always_ff @(posedge sys_clk_i) begin
		if (!resetn_i) begin
			st_q.rdata  <= RST_ZEROS;
			st_q.hit    <= 1'b0;
			st_q.p1_o   <= RST_ZEROS;
			st_q.p1_oe  <= RST_ZEROS;
			st_q.p1_pu  <= RST_ZEROS;
			st_q.p1_rx  <= RST_ZEROS;
			st_q.p1_hd  <= RST_ZEROS;
			st_q.p1_rin <= RST_ZEROS;
			st_q.p2_o   <= RST_ONES;
			st_q.p2_oe  <= RST_ZEROS;
			st_q.p2_pu  <= RST_ONES;
			st_q.p2_rx  <= RST_ONES;
			st_q.p2_sk  <= RST_ZEROS;
		end else begin
			st_q <= st_d;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign sfr_rdata_o     = st_q.rdata;
	assign sfr_hit_o       = st_q.hit;
	assign p1_pin_o        = st_q.p1_o;
	assign p1_pin_oe_o     = st_q.p1_oe;
	assign p1_pullup_en_o  = st_q.p1_pu;
	assign p1_rx_en_o      = st_q.p1_rx;
	assign p1_high_drive_o = st_q.p1_hd;
	assign p1_radio_in_o   = st_q.p1_rin;
	assign p2_pin_o        = st_q.p2_o;
	assign p2_pin_oe_o     = st_q.p2_oe;
	assign p2_pullup_en_o  = st_q.p2_pu;
	assign p2_rx_en_o      = st_q.p2_rx;
	assign p2_skip_o       = st_q.p2_sk;

	logic unused_p1_pin;
	assign unused_p1_pin = ^p1_pin_i;

endmodule : ppc_port_cfg

//--- bench/ppc_pin_model.sv
// ppc_pin_model: port 2 pads with pullups and an outside driver
`timescale 1ns/1ps
module ppc_pin_model
	import ppc_pkg::*;
(
	// clock
	input  wire logic              sys_clk_i,
	// block side
	input  wire logic [DATA_W-1:0] pin_i,
	input  wire logic [DATA_W-1:0] oe_i,
	input  wire logic [DATA_W-1:0] pullup_en_i,
	// outside driver
	input  wire logic [DATA_W-1:0] ext_en_i,
	input  wire logic [DATA_W-1:0] ext_val_i,
	// pad level
	output      logic [DATA_W-1:0] level_o
);
	logic [DATA_W-1:0] drv;
	logic [DATA_W-1:0] val;
	logic              flt_q = 1'b0;
	always @(posedge sys_clk_i) flt_q <= ~flt_q;
	assign drv = oe_i | ext_en_i;
	// wired-and of the block's open drain and the outside driver
	assign val = (pin_i | ~oe_i) & (ext_val_i | ~ext_en_i);
	// released pad: pulled high, else a level that toggles each cycle
	assign level_o = (drv & val) | (~drv & pullup_en_i) | (~drv & ~pullup_en_i & {DATA_W{flt_q}});
endmodule : ppc_pin_model

//--- bench/ppc_port_cfg_asserts.sv
// ppc_port_cfg_asserts: concurrent checks on the port pin configuration block
`timescale 1ns/1ps
module ppc_port_cfg_asserts
	import ppc_pkg::*;
#(
	parameter int unsigned PORT_W = DATA_W
)
(
	// clock and reset
	input wire logic              sys_clk_i,
	input wire logic              resetn_i,
	// register bus
	input wire logic [ADDR_W-1:0] sfr_addr_i,
	input wire logic [PAGE_W-1:0] sfr_page_i,
	input wire logic              sfr_wr_i,
	input wire logic              sfr_rd_i,
	input wire logic              sfr_bit_wr_i,
	input wire logic [DATA_W-1:0] sfr_wdata_i,
	input wire logic [DATA_W-1:0] sfr_rdata_o,
	input wire logic              sfr_hit_o,
	// port 1
	input wire logic [PORT_W-1:0] p1_out_i,
	input wire logic [PORT_W-1:0] p1_pin_oe_o,
	input wire logic [PORT_W-1:0] p1_high_drive_o,
	input wire logic [PORT_W-1:0] p1_radio_in_o,
	// port 2
	input wire logic [PORT_W-1:0] p2_pin_o,
	input wire logic [PORT_W-1:0] p2_pin_oe_o,
	input wire logic [PORT_W-1:0] p2_pullup_en_o,
	input wire logic [PORT_W-1:0] p2_rx_en_o,
	input wire logic [PORT_W-1:0] p2_skip_o
);
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!resetn_i);
	logic quiet;
	assign quiet = !sfr_wr_i && !sfr_bit_wr_i;
	rx_follows_pull_a: assert property (p2_rx_en_o == p2_pullup_en_o)
		else $error("p2 receiver enable differs from pullup");
	rsvd_reads_one_a: assert property (p2_pullup_en_o[7])
		else $error("p2 reserved analog bit low");
	latch_write_a: assert property ((sfr_wr_i && sfr_addr_i == ADDR_P2_DATA) ##1 quiet |=> p2_pin_o == $past(sfr_wdata_i, 2))
		else $error("p2 latch does not follow write");
	open_drain_a: assert property (p2_pin_oe_o == ~p2_pin_o)
		else $error("p2 driver not open drain");
	analog_write_a: assert property ((sfr_wr_i && sfr_addr_i == ADDR_P2_ANALOG && sfr_page_i == PAGE_BASE) ##1 quiet
		|=> p2_pullup_en_o == ($past(sfr_wdata_i, 2) | P2_RSVD_MSK)) else $error("p2 analog select wrong");
	drive_write_a: assert property ((sfr_wr_i && sfr_addr_i == ADDR_P1_OUTDRV && sfr_page_i == PAGE_CONFIG) ##1 quiet
		|=> p1_high_drive_o == ($past(sfr_wdata_i, 2) & ~(P1_RADIO_MSK | P1_NC_MSK)))
		else $error("p1 drive strength wrong");
	skip_write_a: assert property ((sfr_wr_i && sfr_addr_i == ADDR_P2_BYPASS && sfr_page_i == PAGE_BASE) ##1 quiet
		|=> p2_skip_o == $past(sfr_wdata_i, 2)) else $error("p2 skip bits wrong");
	radio_route_a: assert property ($past(resetn_i) |-> p1_radio_in_o == ($past(p1_out_i) & P1_RADIO_MSK))
		else $error("radio pins not routed");
	inner_pins_off_a: assert property ((p1_pin_oe_o & (P1_RADIO_MSK | P1_NC_MSK)) == '0)
		else $error("internal p1 pin driven outside");
	read_hit_a: assert property (sfr_rd_i && sfr_addr_i == ADDR_P2_DATA |=> sfr_hit_o)
		else $error("p2 data read not answered");
	unmapped_read_a: assert property (sfr_rd_i && sfr_addr_i == ADDR_P1_OUTDRV && sfr_page_i != PAGE_BASE
		&& sfr_page_i != PAGE_CONFIG |=> !sfr_hit_o && sfr_rdata_o == '0) else $error("unmapped page answered");
	cover property (sfr_wr_i && sfr_addr_i == ADDR_P2_ANALOG);
	cover property (sfr_bit_wr_i);
	cover property (sfr_rd_i ##1 !sfr_hit_o);
endmodule : ppc_port_cfg_asserts

bind ppc_port_cfg ppc_port_cfg_asserts #(.PORT_W(PORT_W)) chk_i (.sys_clk_i, .resetn_i, .sfr_addr_i, .sfr_page_i,
	.sfr_wr_i, .sfr_rd_i, .sfr_bit_wr_i, .sfr_wdata_i, .sfr_rdata_o, .sfr_hit_o, .p1_out_i, .p1_pin_oe_o,
	.p1_high_drive_o, .p1_radio_in_o, .p2_pin_o, .p2_pin_oe_o, .p2_pullup_en_o, .p2_rx_en_o, .p2_skip_o);

//--- bench/ppc_port_cfg_tb.sv
// ppc_port_cfg_tb: register-level tests of the port pin configuration block
`timescale 1ns/1ps
module ppc_port_cfg_tb;
	import ppc_pkg::*;
	logic       sys_clk_i = 1'b0;
	logic       resetn_i = 1'b0;
	logic       wr = 1'b0, rd = 1'b0, bwr = 1'b0, bval = 1'b0, hit;
	logic [2:0] bidx = 3'h0;
	logic [7:0] addr = 8'h00, page = 8'h00, wdata = 8'h00, p1_out = 8'h00, ext_en = 8'h00, ext_val = 8'h00;
	logic [7:0] rdata, p1_o, p1_oe, p1_pu, p1_rx, p1_hd, p1_radio, p2_o, p2_oe, p2_pu, p2_rx, p2_skip, p2_in;
	int         failures = 0;
	int         n_tests = 0;
	localparam logic [7:0] PG [6] = '{PAGE_BASE, PAGE_BASE, PAGE_CONFIG, PAGE_BASE, PAGE_BASE, PAGE_BASE};
	localparam logic [7:0] AD [6] = '{ADDR_P2_DATA, ADDR_P1_OUTDRV, ADDR_P1_OUTDRV, ADDR_P2_BYPASS, ADDR_P1_ANALOG,
		ADDR_P2_ANALOG};
	localparam logic [7:0] RV [6] = '{RST_ONES, RST_ZEROS, RST_ZEROS, RST_ZEROS, RST_ONES, RST_ONES};
	localparam logic [7:0] WV [6] = '{8'h00, 8'h5A, 8'h3C, 8'h18, 8'h9F, 8'hAA};
	localparam logic [7:0] EV [6] = '{8'h00, 8'h5A, 8'h3C, 8'h18, 8'h9F, 8'hAA};
	always #10 sys_clk_i = ~sys_clk_i;
	ppc_port_cfg dut (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .sfr_addr_i(addr), .sfr_page_i(page),
		.sfr_wr_i(wr), .sfr_rd_i(rd), .sfr_bit_wr_i(bwr), .sfr_bit_idx_i(bidx), .sfr_bit_val_i(bval),
		.sfr_wdata_i(wdata), .sfr_rdata_o(rdata), .sfr_hit_o(hit), .p1_pin_i(8'h00), .p1_pin_o(p1_o),
		.p1_pin_oe_o(p1_oe), .p1_pullup_en_o(p1_pu), .p1_rx_en_o(p1_rx), .p1_high_drive_o(p1_hd),
		.p1_out_i(p1_out), .p1_radio_in_o(p1_radio), .p2_pin_i(p2_in), .p2_pin_o(p2_o), .p2_pin_oe_o(p2_oe),
		.p2_pullup_en_o(p2_pu), .p2_rx_en_o(p2_rx), .p2_skip_o(p2_skip));
	ppc_pin_model pins (.sys_clk_i(sys_clk_i), .pin_i(p2_o), .oe_i(p2_oe), .pullup_en_i(p2_pu),
		.ext_en_i(ext_en), .ext_val_i(ext_val), .level_o(p2_in));
	// ------------------------------------------------------------
	// access tasks
	// ------------------------------------------------------------
	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask : chk
	task automatic reg_wr(input logic [7:0] pg, input logic [7:0] ad, input logic [7:0] d);
		@(negedge sys_clk_i);
		{page, addr, wdata, wr} = {pg, ad, d, 1'b1};
		@(negedge sys_clk_i);
		wr = 1'b0;
	endtask : reg_wr
	task automatic bit_wr(input logic [7:0] pg, input logic [2:0] idx, input logic v);
		@(negedge sys_clk_i);
		{page, addr, bidx, bval, bwr} = {pg, ADDR_P2_DATA, idx, v, 1'b1};
		@(negedge sys_clk_i);
		bwr = 1'b0;
	endtask : bit_wr
	task automatic reg_rd(input logic [7:0] pg, input logic [7:0] ad, input logic [7:0] exp, input logic exp_hit);
		@(negedge sys_clk_i);
		{page, addr, rd} = {pg, ad, 1'b1};
		@(negedge sys_clk_i);
		rd = 1'b0;
		chk("read data", exp, rdata);
		chk("read hit", {7'h00, exp_hit}, {7'h00, hit});
	endtask : reg_rd
	task automatic do_reset;
		@(negedge sys_clk_i);
		resetn_i = 1'b0;
		repeat (12) @(negedge sys_clk_i);
		resetn_i = 1'b1;
		for (int i = 0; i < 6; i++) reg_rd(PG[i], AD[i], RV[i], 1'b1);
		chk("p2 latch out", RST_ONES, p2_o);
		chk("p2 skip out", RST_ZEROS, p2_skip);
	endtask : do_reset
	task automatic complete_run;
		if (failures == 0 && n_tests > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : complete_run
	// ------------------------------------------------------------
	// tests
	// ------------------------------------------------------------
	initial begin
		do_reset();
		p1_out = 8'h35;
		for (int i = 1; i < 6; i++) reg_wr(PG[i], AD[i], WV[i]);
		for (int i = 1; i < 6; i++) reg_rd(PG[i], AD[i], EV[i], 1'b1);
		chk("p1 high drive", 8'h20, p1_hd);
		chk("p1 output enable", 8'hC0, p1_oe);
		chk("p1 pullup", 8'h80, p1_pu);
		chk("p1 receiver", 8'h80, p1_rx);
		chk("p1 radio", 8'h15, p1_radio);
		chk("p1 pin out", 8'h35, p1_o);
		chk("p2 pullup", 8'hAA, p2_pu);
		chk("p2 receiver", 8'hAA, p2_rx);
		chk("p2 skip", 8'h18, p2_skip);
		reg_wr(PAGE_BASE, ADDR_P2_ANALOG, 8'hF0);
		reg_wr(PAGE_CONFIG, ADDR_P2_DATA, 8'h55);
		ext_en = 8'h10;
		reg_rd(8'h03, ADDR_P2_DATA, 8'h40, 1'b1);
		chk("p2 latch out", 8'h55, p2_o);
		chk("p2 output enable", 8'hAA, p2_oe);
		bit_wr(8'h03, 3'h7, 1'b1);
		reg_rd(8'h03, ADDR_P2_DATA, 8'hC0, 1'b1);
		reg_rd(8'h03, ADDR_P1_OUTDRV, 8'h00, 1'b0);
		reg_wr(8'h01, ADDR_P2_BYPASS, 8'hFF);
		reg_rd(PAGE_BASE, ADDR_P2_BYPASS, 8'h18, 1'b1);
		ext_en = 8'h00;
		do_reset();
		complete_run();
	end
	initial begin
		repeat (2000) @(posedge sys_clk_i);
		failures++;
		complete_run();
	end
endmodule : ppc_port_cfg_tb
